/* core/msr_pkg.sv */
// constants shared by the multi-rail supervisor block
// assumes a single 250 MHz core clock and byte-addressed register offsets
package msr_pkg;
	// ---------------------------------------------------------------
	// timebase
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int CNT_W = 32;
	localparam int RESET_MIN_MS = 140;
	// least time: exact at this rate, no rounding needed
	localparam int RESET_MIN_CYC = RESET_MIN_MS * CLK_MHZ * 1000;
	localparam int WDOG_TYP_MS = 1600;
	localparam int WDOG_CYC = WDOG_TYP_MS * CLK_MHZ * 1000;
	localparam int MARGIN_DLY_NS = 1000;
	localparam int MARGIN_DLY_CYC = (MARGIN_DLY_NS * CLK_MHZ + 999) / 1000;
	localparam int RAIL_DEFAULT = 8;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_LIVE = 8'h08;
	localparam logic [7:0] ADDR_EXT_TIMEOUT = 8'h0C;
	localparam int EVT_W = 11;
	localparam int EVT_WDOG = 8;
	localparam int EVT_MANUAL = 9;
	localparam int EVT_RELEASE = 10;
	localparam int LIVE_RESET = 8;
	localparam int LIVE_BAND = 9;
	localparam int LIVE_PEND = 10;
	localparam int LIVE_CAPSEL = 11;
	localparam logic [10:0] STATUS_RST = 11'h000;
	localparam logic [10:0] MASK_RST = 11'h000;
	localparam logic [31:0] EXT_TIMEOUT_RST = 32'h0216_0EC0;
endpackage

/* core/multi_rail_supervisor_reset.sv */
// multi-rail supervisor: per-rail fault flags, stretched system reset,
// watchdog, margin override, small register file with interrupt
// assumes all inputs synchronous to core_clk except the watchdog kick
//
// Operation
// RL1 - each rail flag goes low while its comparator reports below threshold and returns high once it is above again.
// RL2 - system reset goes low as soon as any rail is low or manual reset is pulled low.
// RL3 - once all causes clear, reset stays low for one whole timeout, restarting if a cause returns.
// RL4 - with the internal timeout selected, the stretch lasts at least 140ms.
// RL5 - the stretch length may instead come from an external setting held as a configurable count.
// RL6 - the band select input picks 5% when low and 10% when high, for all rails.
// RL7 - the watchdog asserts reset when the kick input stays quiet longer than its timeout of 1.6s.
// RL8 - an undriven kick input disables the watchdog; otherwise it must toggle within each timeout.
// RL9 - while margin testing, all rail flags and system reset are deasserted.
// RL10 - the rail count is four, six or eight, one flag per rail, all rails feeding the reset.
// RL11 - manual reset is active low and an undriven input counts as inactive.
// RL12 - while margin is held low every output stays high and frozen whatever the rails do; here only rail flags and reset are held, thresholdBand still follows.
// RL13 - the watchdog keeps counting in margin; a timeout then fires reset a fixed delay after release.
// RL14 - the watchdog count restarts on either edge of the kick, after synchronising it.
// RL15 - stretch and watchdog periods come from one timebase with parameterised terminal counts.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module multi_rail_supervisor_reset
	import msr_pkg::*;
#(
	parameter int RAIL_COUNT = RAIL_DEFAULT,
	parameter int RESET_CYCLES = RESET_MIN_CYC,
	parameter int WDOG_CYCLES = WDOG_CYC,
	parameter int MARGIN_CYCLES = MARGIN_DLY_CYC
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [RAIL_COUNT-1:0] railSense,
	input wire logic manualReset_n,
	input wire logic thresholdBandSel,
	input wire logic timeoutCapSel,
	input wire logic marginTest_n,
	input wire logic watchdogKick,
	input wire logic watchdogKickDriven,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	output logic irq,
	output logic [RAIL_COUNT-1:0] railOkFlag,
	output logic sysReset_n,
	output logic thresholdBand
);
	// ---------------------------------------------------------------
	// supervisor state
	// ---------------------------------------------------------------
	logic kickMeta_r, kickSync_r, kickPrev_r;
	logic [CNT_W-1:0] wdCnt_r, wdCnt_nxt;
	logic [CNT_W-1:0] stCnt_r, stCnt_nxt;
	logic [CNT_W-1:0] mdCnt_r, mdCnt_nxt;
	logic mdPend_r, mdPend_nxt;
	logic resetActive_r, resetActive_nxt;
	logic [RAIL_COUNT-1:0] railOkFlag_nxt;
	logic [RAIL_COUNT-1:0] railFaultPrev_r;
	logic sysReset_n_nxt;
	logic mrPrev_r;
	logic thresholdBand_nxt;
	logic kickEdge, wdFire, mdFire, cause;
	logic [RAIL_COUNT-1:0] railFault;
	logic [CNT_W-1:0] extTerm, stTerm;
	// register file
	logic [EVT_W-1:0] status_r, status_nxt, mask_r, mask_nxt, evt;
	logic [31:0] extTimeout_r, extTimeout_nxt;
	logic [31:0] regRdData_nxt, live;
	logic irq_nxt;

	function automatic logic [CNT_W-1:0] cntTerm(input int cycles);
		cntTerm = CNT_W'(cycles - 1);
	endfunction

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		railFault = ~railSense;
		kickEdge = kickSync_r ^ kickPrev_r;
		wdFire = 1'b0;
		mdFire = 1'b0;
		mdPend_nxt = mdPend_r;
		mdCnt_nxt = mdCnt_r;
		// watchdog held idle while reset is out, so it restarts after
		if (!watchdogKickDriven || kickEdge || resetActive_r) begin // RL8 RL14
			wdCnt_nxt = '0;
		end else if (wdCnt_r == cntTerm(WDOG_CYCLES)) begin // RL7 RL15
			wdCnt_nxt = '0;
			wdFire = 1'b1;
		end else begin
			wdCnt_nxt = wdCnt_r + 1'b1;
		end
		// timeout inside margin is parked and replayed after release
		if (!marginTest_n) begin // RL13
			mdCnt_nxt = '0;
			if (wdFire) begin
				mdPend_nxt = 1'b1;
			end
		end else if (mdPend_r) begin
			if (mdCnt_r == cntTerm(MARGIN_CYCLES)) begin // RL13
				mdFire = 1'b1;
				mdPend_nxt = 1'b0;
				mdCnt_nxt = '0;
			end else begin
				mdCnt_nxt = mdCnt_r + 1'b1;
			end
		end
		// zero would never expire, so the register minimum is one cycle
		extTerm = (extTimeout_r == '0) ? 32'h0000_0001 : extTimeout_r;
		stTerm = timeoutCapSel ? CNT_W'(RESET_CYCLES) : extTerm; // RL4 RL5
		cause = (|railFault) || !manualReset_n // RL2 RL10 RL11
			|| (wdFire && marginTest_n) || mdFire; // RL7
		if (cause) begin // RL3
			resetActive_nxt = 1'b1;
			stCnt_nxt = '0;
		end else if (resetActive_r) begin
			// a term shortened mid-stretch must not let the count wrap
			if (stCnt_r >= stTerm - 1'b1) begin // RL3 RL15
				resetActive_nxt = 1'b0;
				stCnt_nxt = '0;
			end else begin
				resetActive_nxt = 1'b1;
				stCnt_nxt = stCnt_r + 1'b1;
			end
		end else begin
			resetActive_nxt = 1'b0;
			stCnt_nxt = '0;
		end
		if (marginTest_n) begin
			railOkFlag_nxt = railSense; // RL1
			sysReset_n_nxt = ~resetActive_nxt; // RL2
		end else begin
			railOkFlag_nxt = '1; // RL9 RL12
			sysReset_n_nxt = 1'b1; // RL9 RL12
		end
		thresholdBand_nxt = thresholdBandSel; // RL6
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			kickMeta_r <= 1'b0;
			kickSync_r <= 1'b0;
			kickPrev_r <= 1'b0;
			wdCnt_r <= '0;
			stCnt_r <= '0;
			mdCnt_r <= '0;
			mdPend_r <= 1'b0;
			resetActive_r <= 1'b1;
			railOkFlag <= '0;
			railFaultPrev_r <= '0;
			sysReset_n <= 1'b0;
			mrPrev_r <= 1'b1;
			thresholdBand <= 1'b0;
		end else begin
			kickMeta_r <= watchdogKick;
			kickSync_r <= kickMeta_r;
			kickPrev_r <= kickSync_r;
			wdCnt_r <= wdCnt_nxt;
			stCnt_r <= stCnt_nxt;
			mdCnt_r <= mdCnt_nxt;
			mdPend_r <= mdPend_nxt;
			resetActive_r <= resetActive_nxt;
			railOkFlag <= railOkFlag_nxt;
			railFaultPrev_r <= railFault;
			sysReset_n <= sysReset_n_nxt;
			mrPrev_r <= manualReset_n;
			thresholdBand <= thresholdBand_nxt;
		end
	end

	// ---------------------------------------------------------------
	// register file and interrupt
	// ---------------------------------------------------------------
	always_comb begin
		evt = '0;
		evt[RAIL_COUNT-1:0] = railFault & ~railFaultPrev_r;
		evt[EVT_WDOG] = wdFire;
		evt[EVT_MANUAL] = mrPrev_r && !manualReset_n;
		evt[EVT_RELEASE] = resetActive_r && !resetActive_nxt;
		live = '0;
		live[RAIL_COUNT-1:0] = railFault;
		live[LIVE_RESET] = resetActive_r;
		live[LIVE_BAND] = thresholdBand;
		live[LIVE_PEND] = mdPend_r;
		live[LIVE_CAPSEL] = timeoutCapSel;
		status_nxt = status_r;
		mask_nxt = mask_r;
		extTimeout_nxt = extTimeout_r;
		if (regWr) begin
			unique case (regAddr)
				ADDR_STATUS: status_nxt = status_r & ~regWrData[EVT_W-1:0];
				ADDR_MASK: mask_nxt = regWrData[EVT_W-1:0];
				ADDR_EXT_TIMEOUT: extTimeout_nxt = regWrData;
				default: status_nxt = status_r;
			endcase
		end
		// an event in the clearing cycle survives the clear
		status_nxt = status_nxt | evt;
		regRdData_nxt = '0;
		if (regRd) begin
			unique case (regAddr)
				ADDR_STATUS: regRdData_nxt = {21'h000000, status_r};
				ADDR_MASK: regRdData_nxt = {21'h000000, mask_r};
				ADDR_LIVE: regRdData_nxt = live;
				ADDR_EXT_TIMEOUT: regRdData_nxt = extTimeout_r;
				default: regRdData_nxt = '0;
			endcase
		end
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_r <= STATUS_RST;
			mask_r <= MASK_RST;
			extTimeout_r <= EXT_TIMEOUT_RST;
			regRdData <= '0;
			irq <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			extTimeout_r <= extTimeout_nxt;
			regRdData <= regRdData_nxt;
			irq <= irq_nxt;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_rail_flag_follow: assert property ( // RL1
		@(posedge core_clk) disable iff (!arst_n)
		(arst_n && marginTest_n) |=> (railOkFlag == $past(railSense)))
		else $error("rail flag does not follow rail level");

	chk_reset_on_cause: assert property ( // RL2
		@(posedge core_clk) disable iff (!arst_n)
		(marginTest_n && (!(&railSense) || !manualReset_n))
			|=> !sysReset_n)
		else $error("reset not asserted on rail low or manual reset");

	chk_stretch_holds: assert property ( // RL3
		@(posedge core_clk) disable iff (!arst_n)
		(resetActive_r && (stCnt_r < stTerm - 1'b1)) |=> resetActive_r)
		else $error("reset released before timeout expired");

	chk_internal_period: assert property ( // RL4
		@(posedge core_clk) disable iff (!arst_n)
		($fell(resetActive_r) && $past(timeoutCapSel))
			|-> ($past(stCnt_r) == cntTerm(RESET_CYCLES)))
		else $error("internal stretch period wrong");

	chk_external_period: assert property ( // RL5
		@(posedge core_clk) disable iff (!arst_n)
		($fell(resetActive_r) && !$past(timeoutCapSel))
			|-> ($past(stCnt_r) == $past(extTerm) - 1'b1))
		else $error("external stretch period wrong");

	chk_band_select: assert property ( // RL6
		@(posedge core_clk) disable iff (!arst_n)
		$changed(thresholdBandSel) |=> (thresholdBand == $past(thresholdBandSel)))
		else $error("band select not taken");

	chk_wdog_fires: assert property ( // RL7
		@(posedge core_clk) disable iff (!arst_n)
		(wdFire && marginTest_n) |=> (resetActive_r && !sysReset_n))
		else $error("watchdog timeout did not assert reset");

	chk_wdog_idle: assert property ( // RL8
		@(posedge core_clk) disable iff (!arst_n)
		!watchdogKickDriven |=> (wdCnt_r == '0))
		else $error("watchdog counts while kick undriven");

	chk_kick_restart: assert property ( // RL14
		@(posedge core_clk) disable iff (!arst_n)
		kickEdge |=> (wdCnt_r == '0))
		else $error("kick edge did not restart watchdog");

	chk_margin_outputs: assert property ( // RL9
		@(posedge core_clk) disable iff (!arst_n)
		(arst_n && !marginTest_n) |=> (sysReset_n && (&railOkFlag)))
		else $error("outputs not deasserted during margin");

	chk_margin_replay: assert property ( // RL13
		@(posedge core_clk) disable iff (!arst_n)
		($rose(marginTest_n) && mdPend_r)
			|-> ##[0:1000] (resetActive_r || !marginTest_n))
		else $error("parked watchdog timeout not replayed");

	chk_wdog_limit: assert property ( // RL15
		@(posedge core_clk) disable iff (!arst_n)
		wdCnt_r <= cntTerm(WDOG_CYCLES))
		else $error("watchdog count beyond its terminal value");

	// read data stands one cycle only, zero otherwise
	chk_read_idle: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(arst_n && !regRd) |=> (regRdData == '0))
		else $error("read data not cleared outside a read");
endmodule // multi_rail_supervisor_reset
`default_nettype wire

/* verif/msr_host_model.sv */
// far-side host: kicks the watchdog and drives the manual reset line
// assumes the bench steers attach, kickOn and manReq after a clock edge
`timescale 1ns/1ps
`default_nettype none
module msr_host_model #(
	parameter int GAP = 10
) (
	input wire logic core_clk,
	input wire logic attach,
	input wire logic kickOn,
	input wire logic manReq,
	output logic watchdogKick,
	output logic watchdogKickDriven,
	output logic manualReset_n
);
	int cnt = 0;
	logic attachQ = 1'b1;
	logic kickQ = 1'b0;
	assign watchdogKick = kickQ;
	assign watchdogKickDriven = attach;
	assign manualReset_n = !manReq;
	// a released pin flips once and then lies still, so no stray kicks
	always @(posedge core_clk) begin
		cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
		attachQ <= attach;
		if (attachQ && !attach)
			kickQ <= !kickQ;
		else if (attach && kickOn && cnt == 0)
			kickQ <= !kickQ;
	end
endmodule // msr_host_model
`default_nettype wire

/* verif/multi_rail_supervisor_reset_tb.sv */
// self-checking bench: integer model of flags and stretched reset
// assumes shortened counts; host model sits on the kick and manual pins
`timescale 1ns/1ps
`default_nettype none
module multi_rail_supervisor_reset_tb;
	import msr_pkg::*;
	localparam int RC = 4, RST = 20, WD = 50, MG = 4, GAP = 10;
	logic core_clk = 0, arst_n = 0, regWr = 0, regRd = 0;
	logic [RC-1:0] railSense = '1, railOkFlag, expF;
	logic thresholdBandSel = 0, timeoutCapSel = 1, marginTest_n = 1;
	logic attach = 1, kickOn = 1, manReq = 0, armF = 0, armR = 0, expR;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0, regRdData, rd, lfsr = 32'h768F;
	logic irq, sysReset_n, thresholdBand;
	wire logic kick, kickDrv, manualReset_n;
	int errors = 0, checks_done = 0, quiet = 0, stTerm = RST, cyc = 0;
	initial forever #2 core_clk = ~core_clk;
	msr_host_model #(.GAP(GAP)) host (.core_clk(core_clk),
		.attach(attach), .kickOn(kickOn), .manReq(manReq),
		.watchdogKick(kick), .watchdogKickDriven(kickDrv),
		.manualReset_n(manualReset_n));
	multi_rail_supervisor_reset #(.RAIL_COUNT(RC), .RESET_CYCLES(RST),
		.WDOG_CYCLES(WD), .MARGIN_CYCLES(MG)) dut (.core_clk(core_clk),
		.arst_n(arst_n), .railSense(railSense),
		.manualReset_n(manualReset_n), .thresholdBandSel(thresholdBandSel),
		.timeoutCapSel(timeoutCapSel), .marginTest_n(marginTest_n),
		.watchdogKick(kick), .watchdogKickDriven(kickDrv),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .irq(irq),
		.railOkFlag(railOkFlag), .sysReset_n(sysReset_n),
		.thresholdBand(thresholdBand));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [31:0] nextLfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic waitCyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic regRead(input logic [7:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(negedge core_clk);
		rd = regRdData;
	endtask
	// wait for the reset output to reach a level, bounded
	task automatic waitRst(input logic lvl, input int n);
		for (int i = 0; i < n && sysReset_n !== lvl; i++)
			@(negedge core_clk);
	endtask
	// ---------------------------------------------------------------
	// reference model and timeout
	// ---------------------------------------------------------------
	// ceiling: all tests need about 1600 cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			print_verdict();
		end
		if (!(&railSense) || !manualReset_n)
			quiet = 0;
		else
			quiet++;
		expF <= marginTest_n ? railSense : '1;
		// release lands stTerm edges after the last cause edge
		expR <= !marginTest_n || quiet >= stTerm;
	end
	always @(negedge core_clk) begin
		if (armF) check(32'(railOkFlag), 32'(expF));
		if (armR) check(32'(sysReset_n), 32'(expR));
	end
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		waitCyc(8);
		arst_n <= 1'b1;
		repeat (RST - 2) @(negedge core_clk);
		check(32'(sysReset_n), 32'h0);
		waitRst(1'b1, 40);
		regRead(ADDR_EXT_TIMEOUT);
		check(rd, EXT_TIMEOUT_RST);
		regRead(8'h10);
		check(rd, 32'h0);
		for (int b = 0; b < 2; b++) begin
			@(posedge core_clk);
			thresholdBandSel <= b[0];
			waitCyc(2);
			check(32'(thresholdBand), 32'(b));
		end
		$display("test registers done");
		armF = 1'b1;
		quiet = 1000;
		@(posedge core_clk);
		armR = 1'b1;
		regWrite(ADDR_STATUS, 32'h7FF);
		regWrite(ADDR_MASK, 32'h1);
		@(posedge core_clk);
		railSense <= 4'hE;
		waitCyc(3);
		check(32'(irq), 32'h1);
		regRead(ADDR_STATUS);
		check(rd, 32'h1);
		regWrite(ADDR_MASK, 32'h0);
		railSense <= '1;
		waitCyc(2);
		check(32'(irq), 32'h0);
		regWrite(ADDR_STATUS, 32'h1);
		regRead(ADDR_STATUS);
		check(rd, 32'h0);
		$display("test interrupt done");
		for (int i = 0; i < 80; i++) begin
			lfsr = nextLfsr(lfsr);
			@(posedge core_clk);
			railSense <= lfsr[5] ? 4'hF : lfsr[3:0];
			manReq <= &lfsr[10:8];
			thresholdBandSel <= lfsr[11];
			marginTest_n <= !(&lfsr[14:12]);
			waitCyc(int'(lfsr[20:16]));
		end
		@(posedge core_clk);
		railSense <= '1;
		manReq <= 1'b0;
		marginTest_n <= 1'b1;
		regWrite(ADDR_EXT_TIMEOUT, 32'h1E);
		timeoutCapSel <= 1'b0;
		@(negedge core_clk) stTerm = 30;
		@(posedge core_clk);
		railSense <= 4'h7;
		@(posedge core_clk);
		railSense <= '1;
		waitCyc(40);
		timeoutCapSel <= 1'b1;
		@(negedge core_clk) stTerm = RST;
		$display("test random and stretch done");
		@(posedge core_clk);
		kickOn <= 1'b0;
		armR = 1'b0;
		repeat (WD - GAP - 1) @(negedge core_clk);
		check(32'(sysReset_n), 32'h1);
		waitRst(1'b0, GAP + 12);
		check(32'(sysReset_n), 32'h0);
		kickOn <= 1'b1;
		regRead(ADDR_STATUS);
		check(32'(rd[EVT_WDOG]), 32'h1);
		waitRst(1'b1, RST + 40);
		@(posedge core_clk);
		attach <= 1'b0;
		// a live watchdog would be mid-stretch at this point
		waitCyc(WD + GAP);
		check(32'(sysReset_n), 32'h1);
		attach <= 1'b1;
		kickOn <= 1'b0;
		marginTest_n <= 1'b0;
		waitCyc(WD + GAP + 10);
		check(32'(sysReset_n), 32'h1);
		marginTest_n <= 1'b1;
		kickOn <= 1'b1;
		repeat (MG - 1) @(negedge core_clk);
		check(32'(sysReset_n), 32'h1);
		waitRst(1'b0, 6);
		check(32'(sysReset_n), 32'h0);
		$display("test watchdog done");
		waitCyc(5);
		print_verdict();
	end
endmodule // multi_rail_supervisor_reset_tb
`default_nettype wire
